// ===== verilog/rtcsp_slave.sv
// Serial slave port giving a bus master byte access to the RTC registers
// What this block does
// - Device acknowledges written bytes while the buffer has room
// - Reads use the internal address counter
// - Address byte loads counter even without data
// - Random read via dummy write, repeated START
// - Master ACK asks for the next byte
// - On NACK release data line, stop sending
// - Serial clock is input only, never stretched
// - Answer only to fixed address D0h/D1h
// - Wrong address: ignore bus until START
// - MSB first, ninth bit is ACK/NACK
`timescale 1ns/1ps
`include "rtcsp_map.svh"
module rtcsp_slave #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe,
    output logic               wr_valid,
    input  wire logic          wr_ready,
    output logic [AW-1:0]      wr_addr,
    output logic [DW-1:0]      wr_data,
    output logic [AW-1:0]      rd_addr,
    input  wire logic [DW-1:0] rd_data,
    output logic               rd_strobe,
    output logic               busy
);
    // =========================================================
    // Pin synchronisers; the first stage feeds only the second
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_d;
    logic       sda_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // Edge and condition detection on the settled levels
    assign scl_rise  = scl_sync[1] && !scl_d;
    assign scl_fall  = !scl_sync[1] && scl_d;
    assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign stop_det  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

    // =========================================================
    // Protocol state
    rtcsp_pkg::rtcsp_state_t state;
    rtcsp_pkg::rtcsp_state_t next_state;
    logic [3:0]    bitcnt;
    logic [3:0]    next_bitcnt;
    logic [7:0]    shreg;
    logic [7:0]    next_shreg;
    logic [AW-1:0] addr_cnt;
    logic [AW-1:0] next_addr_cnt;
    logic          drive_low;
    logic          next_drive_low;
    logic          tx_phase;
    logic          next_tx_phase;
    logic          master_nack;
    logic          next_master_nack;
    logic          push;
    logic          buf_ready;
    logic [7:0]    tx_byte;
    logic          next_rd_strobe;

    // Ninth bit sits at count 8; writes are acked then, reads listen then
    always_comb begin
        next_state       = state;
        next_bitcnt      = bitcnt;
        next_shreg       = shreg;
        next_addr_cnt    = addr_cnt;
        next_drive_low   = drive_low;
        next_tx_phase    = tx_phase;
        next_master_nack = master_nack;
        next_rd_strobe   = 1'b0;
        push             = 1'b0;
        tx_byte          = rd_data;
        if (start_det) begin
            // Any START, repeated or not, restarts address decoding
            next_state     = rtcsp_pkg::RTCSP_DEVA;
            next_bitcnt    = `RTCSP_BIT_PRE; // The clock fall after START is no bit; it wraps this to zero
            next_drive_low = 1'b0;
            next_tx_phase  = 1'b0;
        end else if (stop_det) begin
            next_state     = rtcsp_pkg::RTCSP_IDLE;
            next_drive_low = 1'b0;
        end else if (state != rtcsp_pkg::RTCSP_IDLE && state != rtcsp_pkg::RTCSP_SKIP) begin
            if (scl_rise) begin
                if (bitcnt <= `RTCSP_BIT_LAST) begin
                    next_shreg = {shreg[6:0], sda_sync[1]};
                end else begin
                    next_master_nack = sda_sync[1];
                end
            end
            if (scl_fall) begin
                if (bitcnt == `RTCSP_BIT_LAST && !tx_phase) begin
                    // Received byte complete, decide the ninth bit
                    next_bitcnt = `RTCSP_BIT_ACK;
                    unique case (state)
                        rtcsp_pkg::RTCSP_DEVA: begin
                            if (shreg[7:1] == `RTCSP_SLAVE_ADDR) begin
                                next_drive_low = 1'b1;
                            end else begin
                                next_state = rtcsp_pkg::RTCSP_SKIP;
                            end
                        end
                        rtcsp_pkg::RTCSP_REGA: begin
                            next_addr_cnt  = shreg[AW-1:0];
                            next_drive_low = 1'b1;
                        end
                        rtcsp_pkg::RTCSP_WDATA: begin
                            // A full buffer refuses the byte with NACK
                            next_drive_low = buf_ready;
                            push           = buf_ready;
                            if (buf_ready) begin
                                next_addr_cnt = addr_cnt + 1'b1;
                            end
                        end
                        default: begin
                            next_drive_low = 1'b0;
                        end
                    endcase
                end else if (bitcnt == `RTCSP_BIT_ACK) begin
                    // End of ninth bit: pick what follows
                    next_bitcnt    = 4'h0;
                    next_drive_low = 1'b0;
                    next_tx_phase  = 1'b0;
                    unique case (state)
                        rtcsp_pkg::RTCSP_DEVA: begin
                            if (shreg[0] == `RTCSP_RW_READ) begin
                                next_state     = rtcsp_pkg::RTCSP_RDATA;
                                next_tx_phase  = 1'b1;
                                next_shreg     = tx_byte;
                                next_drive_low = !tx_byte[7];
                                next_rd_strobe = 1'b1;
                                next_addr_cnt  = addr_cnt + 1'b1;
                            end else begin
                                next_state = rtcsp_pkg::RTCSP_REGA;
                            end
                        end
                        rtcsp_pkg::RTCSP_REGA: begin
                            next_state = rtcsp_pkg::RTCSP_WDATA;
                        end
                        rtcsp_pkg::RTCSP_RDATA: begin
                            if (!master_nack) begin
                                next_tx_phase  = 1'b1;
                                next_shreg     = tx_byte;
                                next_drive_low = !tx_byte[7];
                                next_rd_strobe = 1'b1;
                                next_addr_cnt  = addr_cnt + 1'b1;
                            end else begin
                                next_state = rtcsp_pkg::RTCSP_SKIP;
                            end
                        end
                        default: begin
                            next_state = state;
                        end
                    endcase
                end else if (tx_phase) begin
                    // Shift out on falling edge, MSB first
                    if (bitcnt == `RTCSP_BIT_LAST) begin
                        next_bitcnt    = `RTCSP_BIT_ACK;
                        next_drive_low = 1'b0;
                        next_tx_phase  = 1'b0;
                    end else begin
                        next_bitcnt    = bitcnt + 4'h1;
                        next_drive_low = !shreg[6];
                        next_shreg     = {shreg[6:0], 1'b0};
                    end
                end else begin
                    next_bitcnt = bitcnt + 4'h1;
                end
            end
        end
    end

    // Transmit shift register is reused; received bits shift on rise only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state       <= rtcsp_pkg::RTCSP_IDLE;
            bitcnt      <= 4'h0;
            shreg       <= 8'h00;
            addr_cnt    <= `RTCSP_ADDR_RESET;
            drive_low   <= 1'b0;
            tx_phase    <= 1'b0;
            master_nack <= 1'b1;
            rd_strobe   <= 1'b0;
        end else begin
            state       <= next_state;
            bitcnt      <= next_bitcnt;
            shreg       <= tx_phase && scl_rise ? shreg : next_shreg;
            addr_cnt    <= next_addr_cnt;
            drive_low   <= next_drive_low;
            tx_phase    <= next_tx_phase;
            master_nack <= next_master_nack;
            rd_strobe   <= next_rd_strobe;
        end
    end

    // =========================================================
    // Open-drain data pin; clock pin has no driver at all
    assign sda_out = 1'b0;
    assign sda_oe  = drive_low;
    assign rd_addr = addr_cnt;
    assign busy    = (state != rtcsp_pkg::RTCSP_IDLE);

    // Written bytes wait here; a slow register file has two queued, and later bytes are refused with NACK
    rtcsp_buf2 #(
        .WIDTH (AW + DW)
    ) u_wbuf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   ({addr_cnt, shreg}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_addr, wr_data})
    );
endmodule

// ===== inc/rtcsp_map.svh
// Constants for the RTC serial slave port
`ifndef RTCSP_MAP_SVH
`define RTCSP_MAP_SVH
`define RTCSP_SLAVE_ADDR   7'h68
`define RTCSP_RW_READ      1'h1
`define RTCSP_BIT_LAST     4'h7
`define RTCSP_BIT_ACK      4'h8
`define RTCSP_BIT_PRE      4'hF
`define RTCSP_ADDR_RESET   8'h00
`endif

// ===== inc/rtcsp_pkg.sv
// Types for the RTC serial slave port
package rtcsp_pkg;
    typedef enum logic [2:0] {
        RTCSP_IDLE  = 3'b000,
        RTCSP_DEVA  = 3'b001,
        RTCSP_REGA  = 3'b010,
        RTCSP_WDATA = 3'b011,
        RTCSP_RDATA = 3'b100,
        RTCSP_SKIP  = 3'b101
    } rtcsp_state_t;
endpackage

// ===== verilog/rtcsp_buf2.sv
// Two-entry valid/ready buffer for written bytes
`timescale 1ns/1ps
module rtcsp_buf2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic             rd_ptr;
    logic             wr_ptr;
    logic [1:0]       count;
    logic             next_rd_ptr;
    logic             next_wr_ptr;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // =========================================================
    // Pointer and occupancy update
    always_comb begin
        next_mem    = mem;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
        mem <= next_mem;
    end
endmodule

// ===== verification/rtcsp_checker.sv
// Assertion checker for the RTC serial slave port
`timescale 1ns/1ps
module rtcsp_checker #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic          scl_in,
    input wire logic          sda_in,
    input wire logic          sda_out,
    input wire logic          sda_oe,
    input wire logic          wr_valid,
    input wire logic          wr_ready,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    input wire logic [DW-1:0] rd_data,
    input wire logic          rd_strobe,
    input wire logic          busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Bus framing seen on the raw pins
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    property p_start_busy; s_start |-> ##[1:8] busy; endproperty
    a_start_busy: assert property (p_start_busy) else $error("no busy after start");
    property p_stop_idle; s_stop |-> ##[1:8] !busy; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy stuck after stop");
    // Data line only moves while the clock is low, as the sync lag allows
    property p_oe_hold; scl_in [*6] |-> $stable(sda_oe); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("sda moved during clock high");
    property p_idle_quiet; !busy |-> !sda_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");
    property p_reset; $fell(rst) |-> !busy && !sda_oe && !wr_valid && rd_addr == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("stalled byte lost");
    property p_strobe_inc; rd_strobe |-> rd_addr == $past(rd_addr) + 8'h01; endproperty
    a_strobe_inc: assert property (p_strobe_inc) else $error("counter not stepped");
    property p_strobe_pulse; rd_strobe |=> !rd_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
endmodule
bind rtcsp_slave rtcsp_checker #(.AW(AW), .DW(DW)) u_rtcsp_checker (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_strobe(rd_strobe), .busy(busy));

// ===== verification/rtcsp_master.sv
// Bus master model for the serial slave port
`timescale 1ns/1ps
module rtcsp_master (
    input  wire logic core_clk,
    output logic      scl,
    output logic      m_oe,
    input  wire logic sda
);
    logic s;
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One bit: data moves mid clock-low, sampled mid clock-high; clock is push-pull, never held by the device
    task automatic bit_io(input logic b, output logic q);
        scl <= 1'b0;
        w(4);
        m_oe <= !b;
        w(4);
        scl <= 1'b1;
        w(4);
        q = sda;
        w(4);
    endtask
    // Data changes while the clock is high mark START and STOP
    task automatic cond(input logic first, input logic last);
        scl <= 1'b0;
        w(4);
        m_oe <= first;
        w(4);
        scl <= 1'b1;
        w(4);
        m_oe <= last;
        w(8);
    endtask
    task automatic start(); cond(1'b0, 1'b1); endtask
    task automatic stop(); cond(1'b1, 1'b0); endtask
    // Bytes go out MSB first, the ninth bit is the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the RTC serial slave port
`timescale 1ns/1ps
module tb_top;
    logic       core_clk;
    logic       rst;
    logic       scl;
    logic       m_oe;
    logic       wr_ready;
    logic [7:0] rd_data;
    logic       sda_out, sda_oe, wr_valid, rd_strobe, busy;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic       ack;
    logic [7:0] b;
    logic [7:0] bad [2] = '{8'hD2, 8'h50};
    int         n_fail = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         n_strobe = 0;
    // Open-drain data wire with pull-up
    wire        sda = !(sda_oe && !sda_out) && !m_oe;
    rtcsp_master m (.core_clk(core_clk), .scl(scl), .m_oe(m_oe), .sda(sda));
    rtcsp_slave u_rtcsp_slave (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .busy(busy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Register file stand-in: contents derive from the address, one cycle behind
    always @(posedge core_clk) begin
        rd_data <= rd_addr ^ 8'h5A;
        cyc <= cyc + 1;
        // Count latch pulses so every byte sent is seen fetched once
        if (rd_strobe) begin
            n_strobe <= n_strobe + 1;
        end
        if (cyc == 8000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Burst write into a stalled consumer; third byte finds the buffer full
    task automatic t_write();
        m.start();
        m.wbyte(8'hD0, ack);
        chk("ack dev", ack, 1'b0);
        m.wbyte(8'h05, ack);
        chk("ack reg", ack, 1'b0);
        m.wbyte(8'hAA, ack);
        chk("ack d0", ack, 1'b0);
        m.wbyte(8'h55, ack);
        chk("ack d1", ack, 1'b0);
        m.wbyte(8'h77, ack);
        chk("nack full", ack, 1'b1);
        m.stop();
        chk("counter", rd_addr, 8'h07);
        chk("idle", busy, 1'b0);
        chk("waddr0", wr_addr, 8'h05);
        chk("wdata0", wr_data, 8'hAA);
        @(posedge core_clk) wr_ready <= 1'b1;
        @(posedge core_clk) wr_ready <= 1'b0;
        @(posedge core_clk);
        chk("waddr1", wr_addr, 8'h06);
        chk("wdata1", wr_data, 8'h55);
        wr_ready <= 1'b1;
        @(posedge core_clk) wr_ready <= 1'b0;
        @(posedge core_clk);
        chk("drained", wr_valid, 1'b0);
    endtask
    // Dummy write positions the counter, repeated START, burst read
    task automatic t_rdrand();
        m.start();
        m.wbyte(8'hD0, ack);
        m.wbyte(8'h10, ack);
        chk("ack dummy", ack, 1'b0);
        m.start();
        m.wbyte(8'hD1, ack);
        chk("ack rdev", ack, 1'b0);
        for (int i = 0; i < 3; i++) begin
            m.rbyte(i == 2, b);
            chk("rbyte", b, (8'h10 + i[7:0]) ^ 8'h5A);
        end
        m.stop();
        chk("released", sda_oe, 1'b0);
        chk("counter", rd_addr, 8'h13);
    endtask
    // Current-address read of one byte
    task automatic t_rdcur();
        m.start();
        m.wbyte(8'hD1, ack);
        m.rbyte(1'b1, b);
        m.stop();
        chk("cur byte", b, 8'h13 ^ 8'h5A);
        chk("strobes", n_strobe[7:0], 8'h04);
    endtask
    // Foreign addresses: no ACK, and later bytes of that frame ignored
    task automatic t_wrong();
        foreach (bad[k]) begin
            m.start();
            m.wbyte(bad[k], ack);
            chk("nack addr", ack, 1'b1);
            m.wbyte(8'hD0, ack);
            chk("ignored", ack, 1'b1);
            m.stop();
        end
        chk("counter", rd_addr, 8'h14);
    endtask
    initial begin
        rst <= 1'b1;
        wr_ready <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_write();
        t_rdrand();
        t_rdcur();
        t_wrong();
        report_and_stop();
    end
endmodule
